// ### core/tpsb_bank.sv
// Transceiver PHY status register bank with AHB-Lite slave
// Summary of operation
// - Read-only revision word at index zero
// - Scratch word at index one, resets zero
// - Serial TX/RX rates in kHz, 20 bits
// - Core TX/RX rates in kHz, 20 bits
// - Serial clocks run at line rate/40
// - Control bit 31 selects serial loopback
// - Bit 30 reads selected channel each edge
// - Bit 29 writes selected channel each edge
// - Settings bits 28:4 map to readback 24:0
// - Rising inject bit injects one bit error
// - Readback bit 25 valid, bit 26 zero
// - Readback holds last read, resets 0x020080
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
module tpsb_bank #(
	parameter logic [31:0] REVISION    = 32'h0000_0001, // Arbitrary value
	parameter int unsigned GATE_CYCLES = tpsb_pkg::GATE_CYCLES,
	parameter int unsigned KHZ_SCALE   = 1
) (
	// Clock and reset
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	// AHB-Lite slave
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic [31:0]                   hrdata,
	// Monitored clocks
	input  wire logic                     tx_serial_clk,
	input  wire logic                     rx_serial_clk,
	input  wire logic                     tx_core_clk,
	input  wire logic                     rx_core_clk,
	// Transceiver controls
	output logic                          serial_loopback,
	output logic [tpsb_pkg::NUM_CHAN*tpsb_pkg::SET_W-1:0] chan_settings,
	output logic [tpsb_pkg::INJ_W-1:0]    err_inject
);

	tpsb_pkg::tpsb_state_t                state_r;
	logic [9:0]                           addr_r;
	logic                                 accept;
	tpsb_pkg::tpsb_ctrl_t                 ctrl_r;
	logic [31:0]                          scratch_r;
	logic [tpsb_pkg::INJ_W-1:0]           inj_r;
	logic [tpsb_pkg::INJ_W-1:0]           inj_d_r;
	tpsb_pkg::tpsb_reply_t                reply_r;
	logic [tpsb_pkg::SET_W-1:0]           chan_set_r [tpsb_pkg::NUM_CHAN];
	logic                                 chan_ok;
	logic [31:0]                          rd_nxt;
	logic [15:0]                          gate_cnt_r;
	logic                                 gate_tick;
	logic [tpsb_pkg::RATE_W-1:0]          rate [4];
	logic                                 wr_ctrl;
	logic                                 wr_scratch;
	logic                                 wr_inject;

	assign hresp     = 1'b0;
	assign hreadyout = (state_r != tpsb_pkg::ST_RDW);
	assign accept    = hsel && htrans[1] && hready;
	assign chan_ok   = (ctrl_r.chan < tpsb_pkg::CHAN_W'(tpsb_pkg::NUM_CHAN));

	// Bus phase tracking; reads take one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= tpsb_pkg::ST_IDLE;
		end else begin
			case (state_r)
				tpsb_pkg::ST_RDW: begin
					state_r <= tpsb_pkg::ST_RD;
				end
				default: begin
					if (accept && hwrite) begin
						state_r <= tpsb_pkg::ST_WR;
					end else if (accept) begin
						state_r <= tpsb_pkg::ST_RDW;
					end else begin
						state_r <= tpsb_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Address capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_r <= 10'h000;
		end else if (accept) begin
			addr_r <= (haddr[31:12] == 20'h0_0000) ? haddr[11:tpsb_pkg::WORD_LSB] : 10'h3ff;
		end
	end

	assign wr_ctrl    = (state_r == tpsb_pkg::ST_WR) && (addr_r == tpsb_pkg::IDX_ANALOG);
	assign wr_scratch = (state_r == tpsb_pkg::ST_WR) && (addr_r == tpsb_pkg::IDX_SCRATCH);
	assign wr_inject  = (state_r == tpsb_pkg::ST_WR) && (addr_r == tpsb_pkg::IDX_INJECT);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scratch_r <= tpsb_pkg::SCRATCH_RESET;
		end else if (wr_scratch) begin
			scratch_r <= hwdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= tpsb_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_r <= hwdata;
		end
	end

	assign serial_loopback = ctrl_r.loopback;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < tpsb_pkg::NUM_CHAN; i++) begin
				chan_set_r[i] <= tpsb_pkg::SET_RESET;
			end
		end else if (ctrl_r.wr_req && chan_ok) begin
			chan_set_r[ctrl_r.chan] <= ctrl_r.settings;
		end
	end

	genvar gc;
	generate
		for (gc = 0; gc < tpsb_pkg::NUM_CHAN; gc++) begin : g_chan
			assign chan_settings[gc*tpsb_pkg::SET_W +: tpsb_pkg::SET_W] = chan_set_r[gc];
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reply_r <= {6'h00, 1'b0, tpsb_pkg::SET_RESET};
		end else if (ctrl_r.rd_req && chan_ok) begin
			reply_r <= {6'h00, 1'b1, chan_set_r[ctrl_r.chan]};
		end else if (ctrl_r.rd_req) begin
			reply_r.valid <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			inj_r <= tpsb_pkg::INJ_RESET;
		end else if (wr_inject) begin
			inj_r <= hwdata[tpsb_pkg::INJ_W-1:0];
		end
	end

	genvar gb;
	generate
		for (gb = 0; gb < tpsb_pkg::INJ_W; gb++) begin : g_inj
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					inj_d_r[gb]    <= 1'b0;
					err_inject[gb] <= 1'b0;
				end else begin
					inj_d_r[gb]    <= inj_r[gb];
					err_inject[gb] <= inj_r[gb] && !inj_d_r[gb];
				end
			end
		end
	endgenerate

	// Gate timer shared by all monitors
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gate_cnt_r <= 16'h0000;
		end else if (gate_tick) begin
			gate_cnt_r <= 16'h0000;
		end else begin
			gate_cnt_r <= gate_cnt_r + 16'h0001;
		end
	end

	assign gate_tick = (gate_cnt_r == 16'(GATE_CYCLES - 1));

	// Serial monitors see line rate / 40
	tpsb_rate_mon #(.KHZ_SCALE(KHZ_SCALE)) u_tx_serial (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.mon_clk   (tx_serial_clk),
		.gate_tick (gate_tick),
		.rate_khz  (rate[0])
	);
	tpsb_rate_mon #(.KHZ_SCALE(KHZ_SCALE)) u_rx_serial (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.mon_clk   (rx_serial_clk),
		.gate_tick (gate_tick),
		.rate_khz  (rate[1])
	);
	tpsb_rate_mon #(.KHZ_SCALE(KHZ_SCALE)) u_tx_core (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.mon_clk   (tx_core_clk),
		.gate_tick (gate_tick),
		.rate_khz  (rate[2])
	);
	tpsb_rate_mon #(.KHZ_SCALE(KHZ_SCALE)) u_rx_core (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.mon_clk   (rx_core_clk),
		.gate_tick (gate_tick),
		.rate_khz  (rate[3])
	);

	// Read multiplexer
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (addr_r == tpsb_pkg::IDX_REVISION) begin
			rd_nxt = REVISION;
		end else if (addr_r == tpsb_pkg::IDX_SCRATCH) begin
			rd_nxt = scratch_r;
		end else if (addr_r == tpsb_pkg::IDX_TX_SERIAL) begin
			rd_nxt = {12'h000, rate[0]};
		end else if (addr_r == tpsb_pkg::IDX_RX_SERIAL) begin
			rd_nxt = {12'h000, rate[1]};
		end else if (addr_r == tpsb_pkg::IDX_TX_CORE) begin
			rd_nxt = {12'h000, rate[2]};
		end else if (addr_r == tpsb_pkg::IDX_RX_CORE) begin
			rd_nxt = {12'h000, rate[3]};
		end else if (addr_r == tpsb_pkg::IDX_ANALOG) begin
			rd_nxt = ctrl_r;
		end else if (addr_r == tpsb_pkg::IDX_INJECT) begin
			rd_nxt = {30'h0000_0000, inj_r};
		end else if (addr_r == tpsb_pkg::IDX_READBACK) begin
			rd_nxt = reply_r;
		end
	end

	// Read data register, loaded in the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (state_r == tpsb_pkg::ST_RDW) begin
			hrdata <= rd_nxt;
		end
	end

	a_revision_read: assert property (@(posedge hclk) disable iff (!hresetn)
		state_r == tpsb_pkg::ST_RD && addr_r == tpsb_pkg::IDX_REVISION |-> hrdata == REVISION)
		else $error("revision read wrong");

	a_scratch_write: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_scratch |=> scratch_r == $past(hwdata))
		else $error("scratch not written");

	a_loopback_set: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_ctrl |=> serial_loopback == $past(hwdata[31]))
		else $error("loopback not following bit 31");

	a_chan_read: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl_r.rd_req && chan_ok |=>
		reply_r.valid && reply_r.settings == $past(chan_set_r[ctrl_r.chan]))
		else $error("channel read wrong");

	a_chan_write: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl_r.wr_req && chan_ok |=>
		chan_set_r[$past(ctrl_r.chan)] == $past(hwdata[28:4], 1) || $past(wr_ctrl) == 1'b0
		&& chan_set_r[$past(ctrl_r.chan)] == $past(ctrl_r.settings))
		else $error("channel write wrong");

	a_inject_edge: assert property (@(posedge hclk) disable iff (!hresetn)
		err_inject[0] |-> $past(inj_r[0], 1) && !$past(inj_r[0], 2))
		else $error("inject pulse without rising edge");

	a_reply_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
		state_r == tpsb_pkg::ST_RD && addr_r == tpsb_pkg::IDX_READBACK |-> hrdata[31:26] == 6'h00)
		else $error("readback reserved bits set");

	a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		accept && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

endmodule : tpsb_bank

// ### core/tpsb_pkg.sv
// Constants and types for the transceiver PHY status register bank
package tpsb_pkg;

	// Register indices; byte address is four times the index
	localparam logic [9:0]  IDX_REVISION  = 10'h000;
	localparam logic [9:0]  IDX_SCRATCH   = 10'h001;
	localparam logic [9:0]  IDX_TX_SERIAL = 10'h002;
	localparam logic [9:0]  IDX_RX_SERIAL = 10'h003;
	localparam logic [9:0]  IDX_TX_CORE   = 10'h004;
	localparam logic [9:0]  IDX_RX_CORE   = 10'h005;
	localparam logic [9:0]  IDX_ANALOG    = 10'h007;
	localparam logic [9:0]  IDX_INJECT    = 10'h008;
	localparam logic [9:0]  IDX_READBACK  = 10'h009;
	localparam int unsigned WORD_LSB      = 2;

	// Field layout
	localparam int unsigned RATE_W        = 20;
	localparam int unsigned SET_W         = 25;
	localparam int unsigned CHAN_W        = 4;
	localparam int unsigned NUM_CHAN      = 10;
	localparam int unsigned INJ_W         = 2;
	localparam int unsigned SERIAL_DIV    = 40;

	// Reset values
	localparam logic [31:0]      SCRATCH_RESET = 32'h0000_0000;
	localparam logic [31:0]      CTRL_RESET    = 32'h0000_0000;
	localparam logic [SET_W-1:0] SET_RESET     = 25'h002_0080;
	localparam logic [RATE_W-1:0] RATE_RESET   = 20'h0_0000;
	localparam logic [INJ_W-1:0] INJ_RESET     = 2'h0;

	// Gate timing: one millisecond of counting gives kHz directly
	localparam int unsigned CLK_KHZ     = 50000;
	localparam int unsigned GATE_MS     = 1;
	localparam int unsigned GATE_CYCLES = GATE_MS * CLK_KHZ;

	// Analog access control word
	typedef struct packed {
		logic             loopback;
		logic             rd_req;
		logic             wr_req;
		logic [SET_W-1:0] settings;
		logic [CHAN_W-1:0] chan;
	} tpsb_ctrl_t;

	// Analog readback word
	typedef struct packed {
		logic [5:0]       rsvd;
		logic             valid;
		logic [SET_W-1:0] settings;
	} tpsb_reply_t;

	// Bus slave phase tracking
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WR   = 4'h2,
		ST_RDW  = 4'h4,
		ST_RD   = 4'h8
	} tpsb_state_t;

endpackage : tpsb_pkg

// ### core/tpsb_rate_mon.sv
// Clock rate monitor: counts sampled edges over a gate window
`timescale 1ns/1ns
module tpsb_rate_mon #(
	parameter int unsigned KHZ_SCALE = 1
) (
	// Clock and reset
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	// Monitored clock and gate
	input  wire logic                       mon_clk,
	input  wire logic                       gate_tick,
	// Result
	output logic [tpsb_pkg::RATE_W-1:0]     rate_khz
);

	logic        sync1_r;
	logic        sync2_r;
	logic        prev_r;
	logic [23:0] count_r;
	logic [31:0] scaled;

	// Two-stage synchroniser
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r  <= 1'b0;
		end else begin
			sync1_r <= mon_clk;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_r <= 24'h00_0000;
		end else if (gate_tick) begin
			count_r <= 24'h00_0000;
		end else if (sync2_r && !prev_r && count_r != 24'hff_ffff) begin
			count_r <= count_r + 24'h00_0001;
		end
	end

	assign scaled = {8'h00, count_r} * KHZ_SCALE;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rate_khz <= tpsb_pkg::RATE_RESET;
		end else if (gate_tick) begin
			rate_khz <= (scaled[31:20] != 12'h000) ? 20'hf_ffff : scaled[19:0];
		end
	end

	a_rate_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		!$past(gate_tick) |-> $stable(rate_khz))
		else $error("rate changed outside gate");

	a_rate_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		gate_tick |=> count_r == 24'h00_0000)
		else $error("count not cleared at gate");

endmodule : tpsb_rate_mon

// ### verification/tpsb_bank_test.sv
// Self-checking testbench for the PHY status register bank
`timescale 1ns/1ns
module tpsb_bank_test;
	typedef struct packed {
		logic [31:0] addr;
		logic        wr;
		logic [31:0] data;
	} tpsb_row_t;

	localparam logic [31:0] REV = 32'h1234_5678; // Arbitrary value
	localparam int unsigned SW  = tpsb_pkg::SET_W;

	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        tx_serial_clk = 1'b0;
	logic        rx_serial_clk = 1'b0;
	logic        tx_core_clk = 1'b0;
	logic        rx_core_clk = 1'b0;
	logic        serial_loopback;
	logic [tpsb_pkg::NUM_CHAN*SW-1:0] chan_settings;
	logic [1:0]  err_inject;
	logic [31:0] rd;
	int          n_errors = 0;
	int          comparisons = 0;
	int          n_inj0 = 0;
	int          n_inj1 = 0;
	logic [SW-1:0] s1 = 25'h15a_5a5a;
	logic [SW-1:0] s2 = 25'h0f0_f0f0;

	tpsb_row_t rows [18] = '{
		'{32'h08, 1'b0, 32'h0}, '{32'h0c, 1'b0, 32'h0}, '{32'h10, 1'b0, 32'h0},
		'{32'h14, 1'b0, 32'h0}, '{32'h00, 1'b0, REV}, '{32'h04, 1'b0, 32'h0},
		'{32'h04, 1'b1, 32'ha5a5_5a5a}, '{32'h04, 1'b0, 32'ha5a5_5a5a},
		'{32'h00, 1'b1, 32'hffff_ffff}, '{32'h00, 1'b0, REV}, '{32'h1c, 1'b0, 32'h0},
		'{32'h20, 1'b0, 32'h0}, '{32'h24, 1'b0, 32'h0002_0080},
		'{32'h18, 1'b1, 32'hffff_ffff}, '{32'h18, 1'b0, 32'h0}, '{32'h1004, 1'b0, 32'h0},
		'{32'h24, 1'b1, 32'hffff_ffff}, '{32'h24, 1'b0, 32'h0002_0080}};

	tpsb_bank #(.REVISION(REV), .GATE_CYCLES(100), .KHZ_SCALE(500)) u_tpsb_bank (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.tx_serial_clk(tx_serial_clk), .rx_serial_clk(rx_serial_clk),
		.tx_core_clk(tx_core_clk), .rx_core_clk(rx_core_clk),
		.serial_loopback(serial_loopback), .chan_settings(chan_settings),
		.err_inject(err_inject));

	always #10 hclk = ~hclk;
	always #100 tx_serial_clk = ~tx_serial_clk;
	always #200 rx_serial_clk = ~rx_serial_clk;
	always #50 tx_core_clk = ~tx_core_clk;
	always #125 rx_core_clk = ~rx_core_clk;

	// Inject pulse counters
	always @(posedge hclk) begin
		if (err_inject[0] === 1'b1) n_inj0++;
		if (err_inject[1] === 1'b1) n_inj1++;
	end

	task automatic wrap_up();
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_near(input logic [31:0] got, input int exp);
		comparisons++;
		if ($isunknown(got) || int'(got) < exp - 500 || int'(got) > exp + 500) begin
			n_errors++;
			$display("Error at %0t: rate %h near %0d", $time, got, exp);
		end
	endtask : chk_near

	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (n >= 100) begin
			n_errors++;
			$display("Error at %0t: bus hang", $time);
		end
	endtask : wait_ready

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask : bus

	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rows[i]) begin
			bus(rows[i].wr, rows[i].addr, rows[i].data);
			if (!rows[i].wr) chk(rd, rows[i].data);
		end
		$display("test table done");
		bus(1'b1, 32'h1c, 32'h8000_0000);
		@(posedge hclk);
		chk({31'h0, serial_loopback}, 32'h1);
		bus(1'b1, 32'h1c, {3'b001, s1, 4'h3});
		repeat (2) @(posedge hclk);
		chk(32'(chan_settings[3*SW +: SW]), 32'(s1));
		chk(32'(chan_settings[0 +: SW]), 32'(tpsb_pkg::SET_RESET));
		bus(1'b1, 32'h1c, {3'b010, s1, 4'h3});
		@(posedge hclk);
		bus(1'b0, 32'h24, 32'h0);
		chk(rd, {6'h0, 1'b1, s1});
		bus(1'b0, 32'h1c, 32'h0);
		chk(rd, {3'b010, s1, 4'h3});
		// highest channel, then an illegal one
		bus(1'b1, 32'h1c, {3'b001, s2, 4'h9});
		repeat (2) @(posedge hclk);
		chk(32'(chan_settings[9*SW +: SW]), 32'(s2));
		bus(1'b1, 32'h1c, {3'b010, s2, 4'ha});
		@(posedge hclk);
		bus(1'b0, 32'h24, 32'h0);
		chk(rd & 32'h0200_0000, 32'h0);
		$display("test analog done");
		// one pulse per rising inject bit
		bus(1'b1, 32'h20, 32'h1);
		repeat (4) @(posedge hclk);
		chk(32'(n_inj0), 32'h1);
		bus(1'b1, 32'h20, 32'h1);
		repeat (4) @(posedge hclk);
		chk(32'(n_inj0), 32'h1);
		bus(1'b1, 32'h20, 32'h2);
		repeat (4) @(posedge hclk);
		chk({n_inj0[15:0], n_inj1[15:0]}, 32'h0001_0001);
		bus(1'b0, 32'h20, 32'h0);
		chk(rd, 32'h2);
		$display("test inject done");
		repeat (300) @(posedge hclk);
		bus(1'b0, 32'h08, 32'h0);
		chk_near(rd, 5000);
		bus(1'b0, 32'h0c, 32'h0);
		chk_near(rd, 2500);
		bus(1'b0, 32'h10, 32'h0);
		chk_near(rd, 10000);
		bus(1'b0, 32'h14, 32'h0);
		chk_near(rd, 4000);
		$display("test rates done");
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk({31'h0, serial_loopback}, 32'h0);
		chk(32'(chan_settings[3*SW +: SW]), 32'(tpsb_pkg::SET_RESET));
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 32'h04, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 32'h24, 32'h0);
		chk(rd, 32'h0002_0080);
		$display("test reset done");
		wrap_up();
	end

	initial begin
		#400000;
		n_errors++;
		$display("Error at %0t: watchdog", $time);
		wrap_up();
	end
endmodule : tpsb_bank_test
